// [hdl/iocfg_pkg.sv]
package iocfg_pkg;
  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SER_W = 8; // serial lines
  localparam int LINES = 5; // configurable control lines
  localparam int GPIO_LINES = 4; // lines that may be gpio or strobes
  localparam int RX_DEPTH = 256; // receive queue bytes
  localparam int TX_DEPTH = 128; // transmit queue bytes
  localparam int RX_LVL_W = 9;
  localparam int TX_LVL_W = 8;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_BB_DIR = 8'h04;
  localparam logic [7:0] OFS_BB_DATA = 8'h08;
  localparam logic [7:0] OFS_DIVISOR = 8'h0c;
  localparam logic [7:0] OFS_GPIO = 8'h10;
  localparam logic [7:0] OFS_RX_TMO = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DIV_FRAC_LSB = 15; // n in [14:0], eighths in [17:15]
  localparam int GPIO_OUT_LSB = 4; // dir [3:0], out [7:4]
  localparam int GPIO_IN_LSB = 8; // pin levels [11:8], read only
  localparam int ST_BUSY = 0;
  localparam int ST_LOADED = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_TX_FULL = 3;
  localparam int ST_PWR_N = 4;
  localparam int NVM_PD_BIT = 8; // misc word: inv [7:0], pull-down [8]
  localparam logic [1:0] NVM_W_FUNC = 2'h0;
  localparam logic [1:0] NVM_W_MISC = 2'h1;

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [7:0] TMO_RST = 8'h10; // 16 ms
  localparam logic [7:0] TMO_MIN = 8'h01;
  localparam logic [14:0] DIV_N_RST = 15'h0010;
  localparam logic [14:0] DIV_N_MIN = 15'h0002;
  localparam logic [14:0] DIV_N_MAX = 15'h4000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int CLK_HZ = 250_000_000;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] STB_LOAD = 8'(STROBE_CYCLES);
  localparam logic [7:0] LED_MS = 8'h0a;
  localparam int PACE_BASE_HZ = 3_000_000;
  localparam logic [26:0] PACE_ADD = 27'(PACE_BASE_HZ * 8 / 1_000_000);
  localparam logic [25:0] PACE_MUL = 26'(CLK_HZ / 1_000_000);
  localparam int CLKGEN_W = 24;
  localparam longint CLK_FAST_HZ = 48_000_000;
  localparam logic [26:0] CLKGEN_STEP = 27'((CLK_FAST_HZ << CLKGEN_W) / CLK_HZ);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FN_TX_DRIVER_ENABLE = 4'h0,
    FN_POWER_SWITCH_N = 4'h1,
    FN_TX_LED_N = 4'h2,
    FN_RX_LED_N = 4'h3,
    FN_TXRX_LED_N = 4'h4,
    FN_SLEEP_N = 4'h5,
    FN_CLK_OUT_FASTEST = 4'h6,
    FN_CLK_OUT_HALF = 4'h7,
    FN_CLK_OUT_QUARTER = 4'h8,
    FN_CLK_OUT_EIGHTH = 4'h9,
    FN_GPIO = 4'ha,
    FN_BB_WR_N = 4'hb,
    FN_BB_RD_N = 4'hc
  } line_fn_t;
  typedef line_fn_t [LINES-1:0] line_fn_arr_t;
  typedef enum logic [1:0] {
    BB_OFF = 2'h0,
    BB_ASYNC = 2'h1,
    BB_SYNC = 2'h2
  } bb_mode_t;
  typedef struct packed {
    line_fn_arr_t fn;
    logic [SER_W-1:0] inv;
    logic pd;
  } nvm_cfg_t;
endpackage : iocfg_pkg

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; first stage feeds only the second
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta; // first stage, metastable
    logic [W-1:0] stable; // second stage
  } sync_st_t;
  sync_st_t q;
  sync_st_t d;

  // next state
  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
    if (!rstn_in) begin
      d.meta = INIT;
      d.stable = INIT;
    end
  end

  // register
  always_ff @(posedge clk_in) begin
    q <= d;
  end

  assign sync_out = q.stable;
endmodule : pin_sync
`default_nettype wire

// [hdl/line_io_config.sv]
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] five control lines, one function each
// [RULE2] driver enable frames outgoing serial data
// [RULE3] leds pulse on tx, rx, or either
// [RULE4] sleep indicator marks bus suspend
// [RULE5] four continuous clock output frequencies
// [RULE6] lines may carry bit-bang strobes
// [RULE7] bit-bang turns serial lines into gpio
// [RULE8] host bytes driven out at paced rate
// [RULE9] strobes pulse on each port access
// [RULE10] sync mode samples only on write
// [RULE11] four control lines usable as gpio
// [RULE12] gpio works beside normal serial traffic
// [RULE13] pull serial lines low when unpowered
// [RULE14] per-line inversion in both directions
// [RULE15] receive flush timer, 1..255 ms, 16
// [RULE16] receive queue 256, transmit queue 128; the transmit full flag is set at level 127
// [RULE17] internal reset plus external low reset
// [RULE18] sleep low during suspend, else high
// [RULE19] power switch low configured, high suspended
// [RULE20] pace 3000000 over n plus eighths
// [RULE21] load configuration before driving outputs
module line_io_config #(
  parameter int MS_CYCLES = iocfg_pkg::MS_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic EXT_RESETN_IN,
  input wire logic [iocfg_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [iocfg_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [iocfg_pkg::DATA_W-1:0] REG_RDATA_OUT,
  output logic NVM_RD_OUT,
  output logic [1:0] NVM_ADDR_OUT,
  input wire logic [iocfg_pkg::DATA_W-1:0] NVM_DATA_IN,
  input wire logic CONFIGURED_IN,
  input wire logic SUSPEND_IN,
  input wire logic TX_ACTIVE_IN,
  input wire logic TX_EVENT_IN,
  input wire logic RX_EVENT_IN,
  input wire logic [iocfg_pkg::RX_LVL_W-1:0] RX_LEVEL_IN,
  input wire logic [iocfg_pkg::TX_LVL_W-1:0] TX_LEVEL_IN,
  output logic RX_FLUSH_OUT,
  input wire logic [iocfg_pkg::SER_W-1:0] UART_OUT_IN,
  input wire logic [iocfg_pkg::SER_W-1:0] UART_OE_IN,
  output logic [iocfg_pkg::SER_W-1:0] UART_RX_OUT,
  input wire logic [iocfg_pkg::SER_W-1:0] SER_PIN_IN,
  output logic [iocfg_pkg::SER_W-1:0] SER_PIN_OUT,
  output logic [iocfg_pkg::SER_W-1:0] SER_OE_OUT,
  output logic SER_PULLDN_OUT,
  input wire logic [iocfg_pkg::LINES-1:0] LINE_PIN_IN,
  output logic [iocfg_pkg::LINES-1:0] LINE_PIN_OUT,
  output logic [iocfg_pkg::LINES-1:0] LINE_OE_OUT
);
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  // configuration loader, one-hot
  typedef enum logic [3:0] {
    LD_REQ0 = 4'b0001,
    LD_CAP0 = 4'b0010,
    LD_CAP1 = 4'b0100,
    LD_RUN = 4'b1000
  } ld_t;

  typedef struct packed {
    ld_t ld; // loader state
    iocfg_pkg::nvm_cfg_t cfg; // nonvolatile configuration copy
    iocfg_pkg::bb_mode_t mode; // bit-bang mode
    logic [7:0] bb_dir; // 1 = port bit drives
    logic [7:0] bb_hold; // byte waiting for its slot
    logic bb_pend; // hold is full
    logic [7:0] bb_data; // byte on the port
    logic [7:0] bb_in; // last sampled port value
    logic [14:0] div_n; // pacing integer part
    logic [2:0] div_f; // pacing eighths
    logic [25:0] pace_acc; // pacing accumulator
    logic [3:0] gpio_dir; // control-line gpio direction
    logic [3:0] gpio_out; // control-line gpio level
    logic [7:0] tmo; // flush period, ms
    logic [7:0] rxt_cnt; // ms since last receive
    logic [31:0] ms_cnt; // ms prescaler
    logic [7:0] led_tx; // tx led ms left
    logic [7:0] led_rx; // rx led ms left
    logic [7:0] wr_cnt; // write strobe cycles left
    logic [7:0] rd_cnt; // read strobe cycles left
    logic [26:0] clk_acc; // clock-output phase
    logic [31:0] rdata; // read answer
    logic flush; // flush pulse
    logic [7:0] ser_out;
    logic [7:0] ser_oe;
    logic [7:0] uart_rx;
    logic pulldn;
    logic [4:0] line_out;
    logic [4:0] line_oe;
  } st_t;

  st_t q; // registered state
  st_t d; // next state
  logic rst; // combined reset, active high
  logic ext_rstn_s; // external reset, synchronised
  logic [7:0] ser_s; // serial pins, synchronised
  logic [4:0] line_s; // control-line pins, synchronised

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  pin_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(EXT_RESETN_IN),
    .sync_out(ext_rstn_s)
  );
  pin_sync #(.W(iocfg_pkg::SER_W)) u_ser_sync (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(SER_PIN_IN),
    .sync_out(ser_s)
  );
  pin_sync #(.W(iocfg_pkg::LINES)) u_line_sync (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(LINE_PIN_IN),
    .sync_out(line_s)
  );

  // [RULE17] power-on or external reset
  assign rst = !RSTN_IN || !ext_rstn_s;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [26:0] sum;
    logic [25:0] lim;
    logic tick;
    logic ms_tick;
    logic loaded;
    logic pwr_n;
    logic sleep_n;
    logic tx_led_n;
    logic rx_led_n;
    logic [14:0] n_new;
    logic [7:0] t_new;
    sum = '0;
    lim = '0;
    tick = 1'b0;
    ms_tick = 1'b0;
    loaded = (q.ld == LD_RUN);
    pwr_n = 1'b1;
    sleep_n = 1'b1;
    tx_led_n = 1'b1;
    rx_led_n = 1'b1;
    n_new = '0;
    t_new = '0;
    d = q;
    d.rdata = '0;
    d.flush = 1'b0;

    // [RULE21] load configuration words
    case (q.ld)
      LD_REQ0: begin
        d.ld = LD_CAP0;
      end
      LD_CAP0: begin
        d.cfg.fn = iocfg_pkg::line_fn_arr_t'(NVM_DATA_IN[iocfg_pkg::LINES*4-1:0]);
        d.ld = LD_CAP1;
      end
      LD_CAP1: begin
        d.cfg.inv = NVM_DATA_IN[7:0];
        d.cfg.pd = NVM_DATA_IN[iocfg_pkg::NVM_PD_BIT];
        d.ld = LD_RUN;
      end
      LD_RUN: begin
        d.ld = LD_RUN;
      end
      default: begin
        d.ld = LD_REQ0; // illegal code, start over
      end
    endcase

    // ms prescaler shared by flush timer and leds
    if (q.ms_cnt >= 32'(MS_CYCLES - 1)) begin
      d.ms_cnt = '0;
      ms_tick = 1'b1;
    end else begin
      d.ms_cnt = q.ms_cnt + 32'h1;
    end

    // [RULE15] receive flush timer
    if (RX_EVENT_IN || RX_LEVEL_IN == '0) begin
      d.rxt_cnt = '0;
    end else if (ms_tick) begin
      if (q.rxt_cnt >= q.tmo - 8'h01) begin
        d.flush = 1'b1;
        d.rxt_cnt = '0;
      end else begin
        d.rxt_cnt = q.rxt_cnt + 8'h01;
      end
    end

    // [RULE3] led stretchers
    if (TX_EVENT_IN) begin
      d.led_tx = iocfg_pkg::LED_MS;
    end else if (ms_tick && q.led_tx != '0) begin
      d.led_tx = q.led_tx - 8'h01;
    end
    if (RX_EVENT_IN) begin
      d.led_rx = iocfg_pkg::LED_MS;
    end else if (ms_tick && q.led_rx != '0) begin
      d.led_rx = q.led_rx - 8'h01;
    end
    tx_led_n = (q.led_tx == '0);
    rx_led_n = (q.led_rx == '0);

    // [RULE19] power switch level
    pwr_n = !(CONFIGURED_IN && !SUSPEND_IN);
    // [RULE18] sleep indicator
    sleep_n = !SUSPEND_IN;

    // [RULE5] phase accumulator
    d.clk_acc = q.clk_acc + iocfg_pkg::CLKGEN_STEP;

    // strobe countdowns
    if (q.wr_cnt != '0) begin
      d.wr_cnt = q.wr_cnt - 8'h01;
    end
    if (q.rd_cnt != '0) begin
      d.rd_cnt = q.rd_cnt - 8'h01;
    end

    // [RULE20] pacing limit
    lim = 26'((26'(q.div_n) * 26'h8 + 26'(q.div_f)) * iocfg_pkg::PACE_MUL);
    sum = q.pace_acc + iocfg_pkg::PACE_ADD;
    if (q.mode == iocfg_pkg::BB_OFF) begin
      d.pace_acc = '0;
    end else if (sum >= 27'(lim)) begin
      d.pace_acc = 26'(sum - 27'(lim));
      tick = 1'b1;
    end else begin
      d.pace_acc = 26'(sum);
    end

    // [RULE8] paced output slots
    if (tick) begin
      case (q.mode)
        iocfg_pkg::BB_ASYNC: begin
          // [RULE9] read strobe each slot
          d.bb_in = ser_s ^ q.cfg.inv;
          d.rd_cnt = iocfg_pkg::STB_LOAD;
          if (q.bb_pend) begin
            d.bb_data = q.bb_hold;
            d.bb_pend = 1'b0;
            d.wr_cnt = iocfg_pkg::STB_LOAD;
          end
        end
        iocfg_pkg::BB_SYNC: begin
          // [RULE10] sample on write
          if (q.bb_pend) begin
            d.bb_in = ser_s ^ q.cfg.inv;
            d.rd_cnt = iocfg_pkg::STB_LOAD;
            d.bb_data = q.bb_hold;
            d.bb_pend = 1'b0;
            d.wr_cnt = iocfg_pkg::STB_LOAD;
          end
        end
        default: begin
          d.bb_pend = 1'b0;
        end
      endcase
    end

    // register writes
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        iocfg_pkg::OFS_MODE: begin
          d.mode = iocfg_pkg::bb_mode_t'(REG_WDATA_IN[1:0]);
          if (REG_WDATA_IN[1:0] == 2'h3) begin
            d.mode = iocfg_pkg::BB_OFF; // unused code
          end
          if (d.mode == iocfg_pkg::BB_OFF) begin
            d.bb_pend = 1'b0; // drop a waiting byte
          end
        end
        iocfg_pkg::OFS_BB_DIR: begin
          d.bb_dir = REG_WDATA_IN[7:0];
        end
        iocfg_pkg::OFS_BB_DATA: begin
          // refused while a byte still waits or port is off
          if (!q.bb_pend && q.mode != iocfg_pkg::BB_OFF) begin
            d.bb_hold = REG_WDATA_IN[7:0];
            d.bb_pend = 1'b1;
          end
        end
        iocfg_pkg::OFS_DIVISOR: begin
          n_new = REG_WDATA_IN[14:0];
          if (n_new < iocfg_pkg::DIV_N_MIN) begin
            n_new = iocfg_pkg::DIV_N_MIN;
          end
          if (n_new > iocfg_pkg::DIV_N_MAX) begin
            n_new = iocfg_pkg::DIV_N_MAX;
          end
          d.div_n = n_new;
          d.div_f = REG_WDATA_IN[iocfg_pkg::DIV_FRAC_LSB +: 3];
        end
        iocfg_pkg::OFS_GPIO: begin
          d.gpio_dir = REG_WDATA_IN[3:0];
          d.gpio_out = REG_WDATA_IN[iocfg_pkg::GPIO_OUT_LSB +: 4];
        end
        iocfg_pkg::OFS_RX_TMO: begin
          // [RULE15] zero would wrap to a 256 ms period, so it becomes 1 ms
          t_new = REG_WDATA_IN[7:0];
          d.tmo = (t_new < iocfg_pkg::TMO_MIN) ? iocfg_pkg::TMO_MIN : t_new;
        end
        default: begin
          d.tmo = q.tmo; // unmapped write ignored
        end
      endcase
    end

    // register reads, answer stands one cycle
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        iocfg_pkg::OFS_MODE: d.rdata = 32'(q.mode);
        iocfg_pkg::OFS_BB_DIR: d.rdata = 32'(q.bb_dir);
        iocfg_pkg::OFS_BB_DATA: d.rdata = 32'(q.bb_in);
        iocfg_pkg::OFS_DIVISOR: d.rdata = 32'({q.div_f, q.div_n});
        iocfg_pkg::OFS_GPIO: d.rdata = 32'({line_s[3:0], q.gpio_out, q.gpio_dir});
        iocfg_pkg::OFS_RX_TMO: d.rdata = 32'(q.tmo);
        iocfg_pkg::OFS_STATUS: begin
          d.rdata[iocfg_pkg::ST_BUSY] = q.bb_pend;
          d.rdata[iocfg_pkg::ST_LOADED] = loaded;
          // [RULE16] queue fill state
          d.rdata[iocfg_pkg::ST_RX_FULL] =
            (RX_LEVEL_IN >= iocfg_pkg::RX_LVL_W'(iocfg_pkg::RX_DEPTH));
          d.rdata[iocfg_pkg::ST_TX_FULL] =
            (32'(TX_LEVEL_IN) >= 32'(iocfg_pkg::TX_DEPTH - 1));
          d.rdata[iocfg_pkg::ST_PWR_N] = pwr_n;
        end
        default: d.rdata = '0;
      endcase
    end

    // [RULE14] serial lines, inverted both ways
    d.uart_rx = ser_s ^ q.cfg.inv;
    if (!loaded) begin
      d.ser_out = '0;
      d.ser_oe = '0;
    end else if (q.mode == iocfg_pkg::BB_OFF) begin
      // [RULE12] normal serial use
      d.ser_out = UART_OUT_IN ^ q.cfg.inv;
      d.ser_oe = UART_OE_IN;
    end else begin
      // [RULE7] port mode on the serial lines
      d.ser_out = q.bb_data ^ q.cfg.inv;
      d.ser_oe = q.bb_dir;
    end

    // [RULE13] weak pull-down
    d.pulldn = loaded && q.cfg.pd && pwr_n;

    // [RULE1] per-line function select
    for (int i = 0; i < iocfg_pkg::LINES; i++) begin
      d.line_out[i] = 1'b1;
      d.line_oe[i] = loaded;
      case (q.cfg.fn[i])
        // [RULE2] high only while transmitting
        iocfg_pkg::FN_TX_DRIVER_ENABLE: d.line_out[i] = TX_ACTIVE_IN;
        iocfg_pkg::FN_POWER_SWITCH_N: d.line_out[i] = pwr_n;
        iocfg_pkg::FN_TX_LED_N: d.line_out[i] = tx_led_n;
        iocfg_pkg::FN_RX_LED_N: d.line_out[i] = rx_led_n;
        iocfg_pkg::FN_TXRX_LED_N: d.line_out[i] = tx_led_n && rx_led_n;
        // [RULE4] suspend indicator
        iocfg_pkg::FN_SLEEP_N: d.line_out[i] = sleep_n;
        iocfg_pkg::FN_CLK_OUT_FASTEST: d.line_out[i] = q.clk_acc[23];
        iocfg_pkg::FN_CLK_OUT_HALF: d.line_out[i] = q.clk_acc[24];
        iocfg_pkg::FN_CLK_OUT_QUARTER: d.line_out[i] = q.clk_acc[25];
        iocfg_pkg::FN_CLK_OUT_EIGHTH: d.line_out[i] = q.clk_acc[26];
        iocfg_pkg::FN_GPIO: begin
          // [RULE11] first four gpio
          if (i < iocfg_pkg::GPIO_LINES) begin
            d.line_out[i] = q.gpio_out[i[1:0]];
            d.line_oe[i] = loaded && q.gpio_dir[i[1:0]];
          end else begin
            d.line_oe[i] = 1'b0;
          end
        end
        iocfg_pkg::FN_BB_WR_N: begin
          // [RULE6] write strobe
          d.line_out[i] = (q.wr_cnt == '0);
          d.line_oe[i] = loaded && (i < iocfg_pkg::GPIO_LINES);
        end
        iocfg_pkg::FN_BB_RD_N: begin
          // [RULE6] read strobe
          d.line_out[i] = (q.rd_cnt == '0);
          d.line_oe[i] = loaded && (i < iocfg_pkg::GPIO_LINES);
        end
        default: d.line_oe[i] = 1'b0; // unknown code floats
      endcase
    end

    // synchronous reset, all outputs but NVM_RD_OUT quiet
    if (rst) begin
      d = '0;
      d.ld = LD_REQ0;
      d.mode = iocfg_pkg::BB_OFF;
      d.tmo = iocfg_pkg::TMO_RST;
      d.div_n = iocfg_pkg::DIV_N_RST;
      d.line_out = '1;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    q <= d;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // [RULE21] loader owns the storage port
  assign NVM_RD_OUT = (q.ld == LD_REQ0) || (q.ld == LD_CAP0);
  assign NVM_ADDR_OUT = (q.ld == LD_CAP0) ? iocfg_pkg::NVM_W_MISC : iocfg_pkg::NVM_W_FUNC;
  assign REG_RDATA_OUT = q.rdata;
  assign RX_FLUSH_OUT = q.flush;
  assign UART_RX_OUT = q.uart_rx;
  assign SER_PIN_OUT = q.ser_out;
  assign SER_OE_OUT = q.ser_oe;
  assign SER_PULLDN_OUT = q.pulldn;
  assign LINE_PIN_OUT = q.line_out;
  assign LINE_OE_OUT = q.line_oe;
endmodule : line_io_config
`default_nettype wire

// [verification/line_io_config_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module line_io_config_chk (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic NVM_RD_OUT,
  input wire logic [1:0] NVM_ADDR_OUT,
  input wire logic [31:0] NVM_DATA_IN,
  input wire logic CONFIGURED_IN,
  input wire logic SUSPEND_IN,
  input wire logic TX_ACTIVE_IN,
  input wire logic RX_FLUSH_OUT,
  input wire logic SER_PULLDN_OUT,
  input wire logic [7:0] SER_OE_OUT,
  input wire logic [4:0] LINE_PIN_OUT,
  input wire logic [4:0] LINE_OE_OUT
);
  logic [19:0] fn_q; // line roles as the loader took them
  // shadow word0 so role checks follow config
  always_ff @(posedge CLK_IN) begin
    if ($past(NVM_RD_OUT) && $past(NVM_ADDR_OUT) == 2'h0) begin
      fn_q <= NVM_DATA_IN[19:0];
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  AST_FLUSH_ONE: assert property (RX_FLUSH_OUT |=> !RX_FLUSH_OUT)
    else $error("flush pulse too long");
  AST_PD_OFF: assert property ((CONFIGURED_IN && !SUSPEND_IN) [*4] |=> !SER_PULLDN_OUT)
    else $error("pull-down while powered");
  AST_RST_QUIET: assert property ($rose(RSTN_IN) |-> (LINE_OE_OUT == 5'h0 && SER_OE_OUT == 8'h0) [*3])
    else $error("pins driven before load");
  AST_RST_OE: assert property (disable iff (1'b0) !RSTN_IN |=> LINE_OE_OUT == 5'h0 && LINE_PIN_OUT == 5'h1f)
    else $error("lines driven in reset");
  AST_NVM_FIRST: assert property (disable iff (1'b0) !RSTN_IN |=> NVM_RD_OUT && NVM_ADDR_OUT == 2'h0)
    else $error("loader not at first word");
  AST_WR_STROBE: assert property ($fell(LINE_PIN_OUT[0]) && fn_q[3:0] == 4'hb |-> (!LINE_PIN_OUT[0]) [*8] ##1 (!LINE_PIN_OUT[0]) [*2] ##1 LINE_PIN_OUT[0])
    else $error("write strobe width");
  AST_TXEN: assert property (LINE_OE_OUT[3] && fn_q[15:12] == 4'h0 |-> LINE_PIN_OUT[3] == $past(TX_ACTIVE_IN))
    else $error("driver enable mismatch");
  AST_SLEEP: assert property (LINE_OE_OUT[4] && fn_q[19:16] == 4'h5 |-> LINE_PIN_OUT[4] != $past(SUSPEND_IN))
    else $error("sleep line mismatch");
  COV_WR: cover property ($fell(LINE_PIN_OUT[0]));
  COV_FLUSH: cover property (RX_FLUSH_OUT);
  COV_PD: cover property ($rose(SER_PULLDN_OUT));
endmodule : line_io_config_chk
bind line_io_config line_io_config_chk chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
  .NVM_RD_OUT(NVM_RD_OUT), .NVM_ADDR_OUT(NVM_ADDR_OUT), .NVM_DATA_IN(NVM_DATA_IN),
  .CONFIGURED_IN(CONFIGURED_IN), .SUSPEND_IN(SUSPEND_IN), .TX_ACTIVE_IN(TX_ACTIVE_IN),
  .RX_FLUSH_OUT(RX_FLUSH_OUT), .SER_PULLDN_OUT(SER_PULLDN_OUT), .SER_OE_OUT(SER_OE_OUT),
  .LINE_PIN_OUT(LINE_PIN_OUT), .LINE_OE_OUT(LINE_OE_OUT));
`default_nettype wire

// [verification/line_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// storage and pin-side model
// ----
module line_partner (
  input wire logic clk_in,
  input wire logic nvm_rd_in,
  input wire logic [1:0] nvm_addr_in,
  input wire logic [19:0] fn_in,
  output logic [31:0] nvm_data_out,
  input wire logic [7:0] ser_out_in,
  input wire logic [7:0] ser_oe_in,
  output logic [7:0] ser_pin_out,
  input wire logic [4:0] line_out_in,
  input wire logic [4:0] line_oe_in,
  output logic [4:0] line_pin_out
);
  // word0 roles, word1 inv 0f, pull-down on
  always_ff @(posedge clk_in) begin
    if (nvm_rd_in) begin
      nvm_data_out <= (nvm_addr_in == 2'h0) ? {12'h0, fn_in} : 32'h10f;
    end else begin
      // no request: data no longer valid
      nvm_data_out <= ~nvm_data_out;
    end
  end
  // far logic sees what is driven, else the pull-up
  assign ser_pin_out = ser_out_in | ~ser_oe_in;
  assign line_pin_out = line_out_in | ~line_oe_in;
endmodule : line_partner
`default_nettype wire

// [verification/line_io_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module line_io_config_tb;
  // ----
  // stimulus, design, partner
  // ----
  logic CLK_IN = 1'b0;
  logic RSTN_IN = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic wr = 1'b0, rd = 1'b0, cfg = 1'b1, sus = 1'b0, txa = 1'b0, txe = 1'b0, rxe = 1'b0, ern = 1'b1;
  logic [8:0] rxl = 9'h0;
  logic [19:0] fn = 20'h0; // word0 for partner
  logic [31:0] rdat, nda;
  logic [1:0] nad;
  logic [7:0] sout, soe, spin;
  logic [4:0] lout, loe, lpin;
  logic nrd, pdn, fl;
  int err_count = 0;
  int n_tests = 0;
  typedef struct packed {logic we; logic [7:0] a; logic [31:0] w, e;} row_t;
  // optional write, read, expected
  row_t rows[8] = '{'{1'b0, 8'h14, 32'h0, 32'h10}, '{1'b0, 8'h0c, 32'h0, 32'h10},
    '{1'b0, 8'h18, 32'h0, 32'h2},
    '{1'b1, 8'h14, 32'h0, 32'h1}, '{1'b1, 8'h14, 32'hff, 32'hff},
    '{1'b1, 8'h0c, 32'h1, 32'h2}, '{1'b1, 8'h0c, 32'h3ffff, 32'h3c000},
    '{1'b0, 8'h1c, 32'h0, 32'h0}};
  always #2 CLK_IN = ~CLK_IN;
  line_io_config #(.MS_CYCLES(50)) DUT (
    .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .EXT_RESETN_IN(ern), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdat), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
    .NVM_RD_OUT(nrd), .NVM_ADDR_OUT(nad), .NVM_DATA_IN(nda), .CONFIGURED_IN(cfg),
    .SUSPEND_IN(sus), .TX_ACTIVE_IN(txa), .TX_EVENT_IN(txe), .RX_EVENT_IN(rxe),
    .RX_LEVEL_IN(rxl), .TX_LEVEL_IN(8'h0), .RX_FLUSH_OUT(fl), .UART_OUT_IN(8'h0),
    .UART_OE_IN(8'h0), .UART_RX_OUT(), .SER_PIN_IN(spin), .SER_PIN_OUT(sout),
    .SER_OE_OUT(soe), .SER_PULLDN_OUT(pdn), .LINE_PIN_IN(lpin), .LINE_PIN_OUT(lout),
    .LINE_OE_OUT(loe));
  line_partner far (.clk_in(CLK_IN), .nvm_rd_in(nrd), .nvm_addr_in(nad), .fn_in(fn),
    .nvm_data_out(nda), .ser_out_in(sout), .ser_oe_in(soe), .ser_pin_out(spin),
    .line_out_in(lout), .line_oe_in(loe), .line_pin_out(lpin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  // settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_IN);
    #1;
  endtask : cyc
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge CLK_IN);
    wr <= 1'b0;
  endtask : bw
  task automatic br(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK_IN);
    addr <= a;
    rd <= 1'b1;
    @(posedge CLK_IN);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask : br
  // bounded wait for a line to go low
  task automatic wlo(input int i, output int k);
    for (k = 0; lout[i] !== 1'b0 && k < 3000; k++) cyc(1);
    chk(lout[i], 1'b0);
  endtask : wlo
  task automatic rst(input logic [19:0] f);
    fn <= f;
    RSTN_IN <= 1'b0;
    cyc(3);
    chk({loe, soe}, 13'h0);
    RSTN_IN <= 1'b1;
    cyc(8);
  endtask : rst
  task automatic results;
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    int k;
    logic p;
    logic [31:0] v;
    // roles: wr strobe, rd strobe, gpio, driver enable, sleep
    rst(20'h50acb);
    foreach (rows[i]) begin
      if (rows[i].we) bw(rows[i].a, rows[i].w);
      br(rows[i].a, v);
      chk(v, rows[i].e);
    end
    bw(8'h10, 32'h44);
    cyc(4);
    br(8'h10, v);
    chk({v[11:8], loe[2], lout[2]}, 6'h1f);
    sus <= 1'b1;
    txa <= 1'b1;
    cyc(3);
    chk({lout[4], lout[3]}, 2'b01);
    sus <= 1'b0;
    txa <= 1'b0;
    // flush 4 ms after the last receive event
    bw(8'h14, 32'h4);
    rxl <= 9'h5;
    rxe <= 1'b1;
    cyc(1);
    rxe <= 1'b0;
    for (k = 0; fl !== 1'b1 && k < 400; k++) cyc(1);
    chk(k >= 148 && k <= 203, 1'b1);
    rxl <= 9'h0;
    // async port, n = 2: a tick every 166.7 cycles
    bw(8'h0c, 32'h2);
    bw(8'h04, 32'hff);
    bw(8'h00, 32'h1);
    bw(8'h08, 32'h5a);
    wlo(0, k);
    chk({soe, sout}, 16'hff55);
    cyc(12);
    wlo(1, k);
    chk(k >= 152 && k <= 158, 1'b1);
    br(8'h08, v);
    chk(v[7:0], 8'h5a);
    // sync mode: no sampling until a byte goes out
    cyc(12);
    bw(8'h00, 32'h2);
    k = 0;
    repeat (400) begin
      cyc(1);
      k += int'(lout[1] === 1'b0);
    end
    chk(k, 0);
    bw(8'h08, 32'h33);
    wlo(0, k);
    chk({lout[1], sout}, 9'h03c);
    br(8'h08, v);
    chk(v[7:0], 8'h5a);
    // roles: tx led, power switch, both leds, rx led, fastest clock
    rst(20'h63412);
    chk({lout[1], pdn}, 2'b00);
    rxe <= 1'b1;
    cyc(1);
    rxe <= 1'b0;
    cyc(3);
    chk({lout[3], lout[2], lout[0]}, 3'b001);
    txe <= 1'b1;
    cyc(1);
    txe <= 1'b0;
    cyc(400);
    chk({lout[3], lout[2], lout[0]}, 3'b000);
    cyc(200);
    chk({lout[3], lout[2], lout[0]}, 3'b111);
    k = 0;
    p = lout[4];
    repeat (125) begin
      cyc(1);
      k += int'(lout[4] && !p);
      p = lout[4];
    end
    chk({loe[4], k >= 23 && k <= 25}, 2'b11);
    sus <= 1'b1;
    cyc(4);
    chk({lout[1], pdn}, 2'b11);
    ern <= 1'b0;
    cyc(4);
    chk({loe, lout}, 10'h1f);
    results();
  end
endmodule : line_io_config_tb
`default_nettype wire
